// >>> verilog/dttd_pkg.sv
/*
 * Package for the dual timer transmit/demodulation block: register
 * addresses, field positions, reset values and the carrier types.
 * Assumes an 8-bit register port with 12-bit linear addresses.
 */
package dttd_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] ADDR_TIMER8_CTL = 12'h0d00;
    localparam logic [11:0] ADDR_SHARED_CTL = 12'h0d01;
    localparam logic [11:0] ADDR_SECOND_CTL = 12'h0d02;
    localparam logic [11:0] ADDR_THIRD_CTL  = 12'h0d03;
    localparam logic [11:0] ADDR_T8_LOW     = 12'h0d04;
    localparam logic [11:0] ADDR_T8_HIGH    = 12'h0d05;
    localparam logic [11:0] ADDR_T16_LOW    = 12'h0d06;
    localparam logic [11:0] ADDR_T16_HIGH   = 12'h0d07;
    localparam logic [11:0] ADDR_CAP8_LOW   = 12'h0d08;
    localparam logic [11:0] ADDR_CAP8_HIGH  = 12'h0d09;
    localparam logic [11:0] ADDR_CAP16_LOW  = 12'h0d0a;
    localparam logic [11:0] ADDR_CAP16_HIGH = 12'h0d0b;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int T8C_ENABLE   = 7;
    localparam int T8C_SINGLE   = 6;
    localparam int T8C_TIMEOUT  = 5;
    localparam int T8C_PRE_HI   = 4;
    localparam int T8C_PRE_LO   = 3;
    localparam int T8C_CAP_IE   = 2;
    localparam int T8C_TO_IE    = 1;
    localparam int T8C_PIN_SEL  = 0;
    localparam int SH_MODE      = 7;
    localparam int SH_PIN_INSEL = 6;
    localparam int SH_LOGIC_HI  = 5;
    localparam int SH_LOGIC_LO  = 4;
    localparam int SH_INIT8     = 1;
    localparam int SH_INIT16    = 0;
    localparam int C2_ENABLE    = 7;
    localparam int C2_SINGLE    = 6;
    localparam int C2_TIMEOUT   = 5;
    localparam int C2_PRE_HI    = 4;
    localparam int C2_PRE_LO    = 3;
    localparam int C3_ENABLE8   = 6;

    // ------------------------------------------------------------
    // Reset values and counter constants
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [7:0]  TERM8       = 8'h01;
    localparam logic [15:0] TERM16      = 16'h0001;
    localparam logic [2:0]  PRESC_RST   = 3'h0;
    // Bits of the 8-bit control kept by a stop-mode recovery
    localparam logic [7:0]  T8C_KEEP    = 8'h1e;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } dttd_bus_t;

    typedef struct packed {
        logic [7:0]  timer8_control;
        logic [7:0]  shared_timer_mode_control;
        logic [7:0]  second_timer_control;
        logic [7:0]  third_timer_control;
        logic [7:0]  timer8_low_hold;
        logic [7:0]  timer8_high_hold;
        logic [7:0]  timer16_low_hold;
        logic [7:0]  timer16_high_hold;
        logic [7:0]  cap8_low;
        logic [7:0]  cap8_high;
        logic [15:0] cap16;
        logic [7:0]  cnt8;
        logic [15:0] cnt16;
        logic [2:0]  presc;
        logic        out8;
        logic        out16;
        logic        run8;
        logic        run16;
        logic        arm16;
        logic        en8_prev;
        logic        en16_prev;
        logic        din_prev;
        logic [7:0]  rdata;
        logic        pin4;
        logic        pin6;
        logic        irq_to;
        logic        irq_cap;
        logic        external_interrupt_one;
    } dttd_state_t;

endpackage

// >>> verilog/dttd_top.sv
/*
 * Dual timer: an 8-bit and a 16-bit counter with hold registers, a
 * transmit mode that drives waveforms on two port pins and a
 * demodulation mode that captures edge timing of a selected input.
 * Assumes synchronous pin inputs and a one-cycle register port.
 */
`timescale 1ns/10ps

module dttd_top (
    input  wire logic              I_MCLK,
    input  wire logic              I_RST_N,
    input  wire logic              I_STOP_RECOVER,
    input  wire dttd_pkg::dttd_bus_t I_BUS,
    input  wire logic              I_PORT3_PIN4_PORT,
    input  wire logic              I_PORT3_PIN6_PORT,
    input  wire logic              I_PORT3_PIN1,
    input  wire logic              I_PORT2_PIN0,
    input  wire logic              I_IMR_PIN1_EN,
    output logic [7:0]             O_RDATA,
    output logic                   O_PORT3_PIN4,
    output logic                   O_PORT3_PIN6,
    output logic                   O_T8_TIMEOUT_IRQ,
    output logic                   O_CAPTURE_IRQ,
    output logic                   O_EXT_EXTERNAL_INTERRUPT_ONE
);
    import dttd_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Prescaler tick for a 2-bit divide code
    function automatic logic presc_hit(input logic [2:0] p,
                                       input logic [1:0] sel);
        case (sel)
            2'b00:   presc_hit = 1'b1;
            2'b01:   presc_hit = p[0];
            2'b10:   presc_hit = &p[1:0];
            default: presc_hit = &p;
        endcase
    endfunction

    // Combined transmit output: AND, OR, NOR, NAND
    function automatic logic combine(input logic a, input logic b,
                                     input logic [1:0] sel);
        case (sel)
            2'b00:   combine = a & b;
            2'b01:   combine = a | b;
            2'b10:   combine = ~(a | b);
            default: combine = ~(a & b);
        endcase
    endfunction

    dttd_state_t s_q;
    dttd_state_t s_d;
    logic        en8;
    logic        start8;
    logic        tick8;
    logic        term8;
    logic        en16;
    logic        start16;
    logic        tick16;
    logic        term16;
    logic        demod;
    logic        din;
    logic        rise;
    logic        fall;
    logic        edge8;
    logic        edge16;
    logic        wr_ctl8;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d     = s_q;
        demod   = s_q.shared_timer_mode_control[SH_MODE];
        en8     = s_q.timer8_control[T8C_ENABLE]
                | s_q.third_timer_control[C3_ENABLE8];
        start8  = en8 & ~s_q.en8_prev;
        en16    = s_q.second_timer_control[C2_ENABLE];
        start16 = en16 & ~s_q.en16_prev;
        tick8   = presc_hit(s_q.presc,
                    s_q.timer8_control[T8C_PRE_HI:T8C_PRE_LO]);
        tick16  = presc_hit(s_q.presc,
                    s_q.second_timer_control[C2_PRE_HI:C2_PRE_LO]);
        // Demodulator input select
        din     = s_q.shared_timer_mode_control[SH_PIN_INSEL]
                ? I_PORT2_PIN0 : I_PORT3_PIN1;
        rise    = demod & din & ~s_q.din_prev;
        fall    = demod & ~din & s_q.din_prev;
        edge8   = s_q.run8 & ((rise & s_q.shared_timer_mode_control[SH_INIT8])
                | (fall & s_q.shared_timer_mode_control[SH_INIT16]));
        case (s_q.shared_timer_mode_control[SH_LOGIC_HI:SH_LOGIC_LO])
            2'b00:   edge16 = fall;
            2'b01:   edge16 = rise;
            default: edge16 = rise | fall;
        endcase
        // Edges win over ticks so a capture never also times out
        // A disable landing this cycle also blocks a stray time-out
        term8   = en8 & s_q.run8 & tick8 & ~edge8 & (s_q.cnt8 == TERM8);
        term16  = en16 & s_q.run16 & tick16 & ~(demod & edge16)
                & (s_q.cnt16 == TERM16);
        wr_ctl8 = I_BUS.wr & (I_BUS.addr == ADDR_TIMER8_CTL);

        s_d.presc     = s_q.presc + 3'h1;
        s_d.en8_prev  = en8;
        s_d.en16_prev = en16;
        s_d.din_prev  = din;

        // 8-bit timer
        if (!en8) begin
            s_d.run8 = 1'b0;
        end else if (start8) begin
            s_d.run8 = 1'b1;
            s_d.out8 = demod ? 1'b0 : s_q.shared_timer_mode_control[SH_INIT8];
            s_d.cnt8 = (demod | s_q.shared_timer_mode_control[SH_INIT8])
                     ? s_q.timer8_high_hold : s_q.timer8_low_hold;
        end else if (edge8) begin
            // Rising edge ends a low period, falling edge a high one
            if (rise)
                s_d.cap8_low = s_q.cnt8;
            else
                s_d.cap8_high = s_q.cnt8;
            s_d.cnt8 = s_q.timer8_high_hold;
        end else if (s_q.run8 && tick8) begin
            if (s_q.cnt8 == TERM8) begin
                if (demod) begin
                    s_d.cnt8 = s_q.timer8_high_hold;
                end else begin
                    s_d.out8 = ~s_q.out8;
                    s_d.cnt8 = s_q.out8 ? s_q.timer8_low_hold
                                        : s_q.timer8_high_hold;
                end
                if (s_q.timer8_control[T8C_SINGLE])
                    s_d.run8 = 1'b0;
            end else begin
                s_d.cnt8 = s_q.cnt8 - 8'h01;
            end
        end

        // 16-bit timer
        if (!en16) begin
            s_d.run16 = 1'b0;
            s_d.arm16 = 1'b0;
        end else if (start16) begin
            // Demod waits for the first edge before counting
            s_d.run16 = ~demod;
            s_d.arm16 = demod;
            s_d.out16 = s_q.shared_timer_mode_control[SH_INIT16];
            s_d.cnt16 = {s_q.timer16_high_hold,
                         s_q.timer16_low_hold};
        end else if (demod && edge16 && (s_q.arm16 || s_q.run16)) begin
            s_d.cap16 = s_q.cnt16;
            s_d.cnt16 = {s_q.timer16_high_hold, s_q.timer16_low_hold};
            s_d.run16 = 1'b1;
            s_d.arm16 = 1'b0;
        end else if (s_q.run16 && tick16) begin
            if (s_q.cnt16 == TERM16) begin
                s_d.out16 = demod ? s_q.out16 : ~s_q.out16;
                s_d.cnt16 = {s_q.timer16_high_hold, s_q.timer16_low_hold};
                if (s_q.second_timer_control[C2_SINGLE] && !demod)
                    s_d.run16 = 1'b0;
            end else begin
                // Zero steps to FFFFh with no time-out
                s_d.cnt16 = s_q.cnt16 - 16'h0001;
            end
        end

        // Register writes
        if (I_BUS.wr) begin
            case (I_BUS.addr)
                ADDR_TIMER8_CTL: begin
                    s_d.timer8_control[7:6] = I_BUS.wdata[7:6];
                    s_d.timer8_control[4:0] = I_BUS.wdata[4:0];
                end
                ADDR_SHARED_CTL:
                    s_d.shared_timer_mode_control = I_BUS.wdata;
                ADDR_SECOND_CTL: begin
                    s_d.second_timer_control[7:6] = I_BUS.wdata[7:6];
                    s_d.second_timer_control[4:0] = I_BUS.wdata[4:0];
                end
                ADDR_THIRD_CTL: s_d.third_timer_control = I_BUS.wdata;
                ADDR_T8_LOW:    s_d.timer8_low_hold     = I_BUS.wdata;
                ADDR_T8_HIGH:   s_d.timer8_high_hold    = I_BUS.wdata;
                ADDR_T16_LOW:   s_d.timer16_low_hold    = I_BUS.wdata;
                ADDR_T16_HIGH:  s_d.timer16_high_hold   = I_BUS.wdata;
                default: ;
            endcase
        end

        // Time-out flags: write one clears, a set in the same cycle wins
        s_d.timer8_control[T8C_TIMEOUT] = term8 |
            (s_q.timer8_control[T8C_TIMEOUT]
             & ~(wr_ctl8 & I_BUS.wdata[T8C_TIMEOUT]));
        s_d.second_timer_control[C2_TIMEOUT] = term16 |
            (s_q.second_timer_control[C2_TIMEOUT]
             & ~(I_BUS.wr & (I_BUS.addr == ADDR_SECOND_CTL)
                 & I_BUS.wdata[C2_TIMEOUT]));

        // Stop-mode recovery: holds and sticky control bits survive
        if (I_STOP_RECOVER) begin
            s_d.timer8_control = s_q.timer8_control & T8C_KEEP;
            s_d.shared_timer_mode_control = RST_BYTE;
            s_d.second_timer_control      = RST_BYTE;
            s_d.third_timer_control       = RST_BYTE;
            s_d.run8  = 1'b0;
            s_d.run16 = 1'b0;
            s_d.arm16 = 1'b0;
            s_d.out8  = 1'b0;
            s_d.out16 = 1'b0;
        end

        // Read data, valid the cycle after the strobe
        s_d.rdata = RST_BYTE;
        if (I_BUS.rd) begin
            case (I_BUS.addr)
                ADDR_TIMER8_CTL: s_d.rdata = s_q.timer8_control;
                ADDR_SHARED_CTL: s_d.rdata = s_q.shared_timer_mode_control;
                ADDR_SECOND_CTL: s_d.rdata = s_q.second_timer_control;
                ADDR_THIRD_CTL:  s_d.rdata = s_q.third_timer_control;
                ADDR_T8_LOW:     s_d.rdata = s_q.timer8_low_hold;
                ADDR_T8_HIGH:    s_d.rdata = s_q.timer8_high_hold;
                ADDR_T16_LOW:    s_d.rdata = s_q.timer16_low_hold;
                ADDR_T16_HIGH:   s_d.rdata = s_q.timer16_high_hold;
                ADDR_CAP8_LOW:   s_d.rdata = s_q.cap8_low;
                ADDR_CAP8_HIGH:  s_d.rdata = s_q.cap8_high;
                ADDR_CAP16_LOW:  s_d.rdata = s_q.cap16[7:0];
                ADDR_CAP16_HIGH: s_d.rdata = s_q.cap16[15:8];
                default:         s_d.rdata = RST_BYTE;
            endcase
        end

        // Pins and interrupt pulses, registered
        s_d.pin4 = s_q.timer8_control[T8C_PIN_SEL]
                 ? s_q.out8 : I_PORT3_PIN4_PORT;
        s_d.pin6 = (!demod && s_q.shared_timer_mode_control[SH_PIN_INSEL])
                 ? combine(s_q.out8, s_q.out16,
                   s_q.shared_timer_mode_control[SH_LOGIC_HI:SH_LOGIC_LO])
                 : I_PORT3_PIN6_PORT;
        s_d.irq_to  = term8 & s_q.timer8_control[T8C_TO_IE];
        s_d.irq_cap = edge8 & en8 & ~start8
                    & s_q.timer8_control[T8C_CAP_IE];
        s_d.external_interrupt_one    = (rise | fall)
                    & ~s_q.shared_timer_mode_control[SH_PIN_INSEL]
                    & I_IMR_PIN1_EN;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // Outputs straight from flops
    assign O_RDATA          = s_q.rdata;
    assign O_PORT3_PIN4     = s_q.pin4;
    assign O_PORT3_PIN6     = s_q.pin6;
    assign O_T8_TIMEOUT_IRQ = s_q.irq_to;
    assign O_CAPTURE_IRQ    = s_q.irq_cap;
    assign O_EXT_EXTERNAL_INTERRUPT_ONE       = s_q.external_interrupt_one;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);

    hold_keep_a:
    assert property (I_STOP_RECOVER && !I_BUS.wr
                     |=> $stable(s_q.timer16_low_hold)
                         && $stable(s_q.timer8_high_hold))
        else $error("hold register changed on stop recovery");
    enable_or_a:
    assert property (!s_q.timer8_control[T8C_ENABLE]
                     && !s_q.third_timer_control[C3_ENABLE8] |=> !s_q.run8)
        else $error("8-bit timer runs with both enables low");
    single_stop_a:
    assert property (term8 && s_q.timer8_control[T8C_SINGLE]
                     && !I_STOP_RECOVER |=> !s_q.run8)
        else $error("single pass did not stop");
    flag_set_a:
    assert property (term8 |=> s_q.timer8_control[T8C_TIMEOUT])
        else $error("time-out flag not set");
    flag_clear_a:
    assert property (wr_ctl8 && I_BUS.wdata[T8C_TIMEOUT] && !term8
                     |=> !s_q.timer8_control[T8C_TIMEOUT])
        else $error("time-out flag not cleared");
    to_irq_a:
    assert property (O_T8_TIMEOUT_IRQ
                     |-> $past(term8 && s_q.timer8_control[T8C_TO_IE]))
        else $error("time-out interrupt without cause");
    pin4_route_a:
    assert property (s_q.timer8_control[T8C_PIN_SEL]
                     |=> O_PORT3_PIN4 == $past(s_q.out8))
        else $error("port3 pin4 not carrying timer output");
    toggle_reload_a:
    assert property (term8 && !demod && !I_STOP_RECOVER && !I_BUS.wr
                     |=> s_q.out8 != $past(s_q.out8)
                         && s_q.cnt8 == (s_q.out8 ? s_q.timer8_high_hold
                                                  : s_q.timer8_low_hold))
        else $error("transmit toggle or reload wrong");
    wrap_zero_a:
    assert property (s_q.run16 && tick16 && s_q.cnt16 == 16'h0000
                     && !demod && en16 && !I_STOP_RECOVER
                     |=> s_q.cnt16 == 16'hffff
                         && !$rose(s_q.second_timer_control[C2_TIMEOUT]))
        else $error("zero count did not wrap quietly");
    cap_irq_a:
    assert property (O_CAPTURE_IRQ
                     |-> $past(s_q.timer8_control[T8C_CAP_IE] && edge8))
        else $error("capture interrupt without enable");

    toggle_c:  cover property (term8 && !demod);
    capture_c: cover property (demod && edge16 && s_q.arm16);
    pin6_c:    cover property (!demod && s_q.pin6 != $past(s_q.pin6));
    external_interrupt_one_c:    cover property (O_EXT_EXTERNAL_INTERRUPT_ONE);

endmodule // dttd_top

// >>> testbench/dttd_pin_model.sv
/*
 * Far-side pin model: drives the two demodulator inputs and times the
 * levels that the block puts on port3 pin4.
 * Assumes one clock and synchronous, idle-low demodulator inputs.
 */
`timescale 1ns/10ps

module dttd_pin_model (
    input  wire logic i_clk,
    input  wire logic i_pin4,
    output logic      o_pin1,
    output logic      o_pin0,
    output int        o_hi_w,
    output int        o_lo_w,
    output int        o_toggles
);
    int   run_cnt;
    logic last_q;

    initial begin
        o_pin1    = 1'b0;
        o_pin0    = 1'b0;
        o_hi_w    = 0;
        o_lo_w    = 0;
        o_toggles = 0;
        run_cnt   = 1;
        last_q    = 1'b0;
    end

    // Width of each finished level; the first one seen may be partial
    always @(posedge i_clk) begin
        if (i_pin4 !== last_q) begin
            if (last_q)
                o_hi_w <= run_cnt;
            else
                o_lo_w <= run_cnt;
            o_toggles <= o_toggles + 1;
            run_cnt   <= 1;
        end else
            run_cnt <= run_cnt + 1;
        last_q <= i_pin4;
    end

    // One pulse, held long enough that both of its edges are seen
    task automatic pulse(input bit which);
        @(posedge i_clk);
        if (which)
            o_pin0 <= 1'b1;
        else
            o_pin1 <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_pin1 <= 1'b0;
        o_pin0 <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
endmodule // dttd_pin_model

// >>> testbench/dttd_top_tb.sv
/*
 * Self-checking bench for the dual timer: register port tasks and
 * directed sequences with expected values.
 * Assumes the pin model beside it and a 100 MHz clock.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    error_cnt++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module dttd_top_tb;
    import dttd_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       stop_q = 1'b0;
    logic       p4_q = 1'b0;
    logic       p6_q = 1'b0;
    logic       imr_q = 1'b0;
    dttd_bus_t  bus_q = '0;
    logic [7:0] rdata, d;
    logic       pin4, pin6, to_irq, cap_irq, ext_irq, pin1, pin0;
    int         hi_w, lo_w, tgl, t0, i0, c0, e0;
    int         error_cnt = 0, n_compared = 0;
    int         irq_cnt = 0, cap_cnt = 0, ext_cnt = 0;

    always #5 clk = ~clk;

    dttd_top dut_u (.I_MCLK(clk), .I_RST_N(rst_n), .I_STOP_RECOVER(stop_q),
        .I_BUS(bus_q), .I_PORT3_PIN4_PORT(p4_q), .I_PORT3_PIN6_PORT(p6_q),
        .I_PORT3_PIN1(pin1), .I_PORT2_PIN0(pin0), .I_IMR_PIN1_EN(imr_q),
        .O_RDATA(rdata), .O_PORT3_PIN4(pin4), .O_PORT3_PIN6(pin6),
        .O_T8_TIMEOUT_IRQ(to_irq), .O_CAPTURE_IRQ(cap_irq),
        .O_EXT_EXTERNAL_INTERRUPT_ONE(ext_irq));
    dttd_pin_model pm_u (.i_clk(clk), .i_pin4(pin4), .o_pin1(pin1),
        .o_pin0(pin0), .o_hi_w(hi_w), .o_lo_w(lo_w), .o_toggles(tgl));

    // Pulse counters; the outputs stand for one cycle only
    always @(posedge clk) begin
        if (to_irq === 1'b1) irq_cnt++;
        if (cap_irq === 1'b1) cap_cnt++;
        if (ext_irq === 1'b1) ext_cnt++;
    end

    // -------------------------------------------------------------
    // Register port tasks
    // -------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_q <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_q.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge clk);
        bus_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_q.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic give_verdict();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard: counts as a mismatch
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_SHARED_CTL, d); `CHK("shared rst", 8'h00, d)
        rd(ADDR_T8_HIGH, d); `CHK("t8 high rst", 8'h00, d)
        rd(ADDR_T16_LOW, d); `CHK("t16 low rst", 8'h00, d)
        rd(12'h0000, d); `CHK("unmapped", 8'h00, d)
        wr(ADDR_T16_LOW, 8'ha5); rd(ADDR_T16_LOW, d);
        `CHK("t16 low a5", 8'ha5, d)
        wr(ADDR_T16_LOW, 8'h5a); rd(ADDR_T16_LOW, d);
        `CHK("t16 low 5a", 8'h5a, d)
        // Stop recovery keeps holds and the prescale and interrupt enable bits
        wr(ADDR_T8_HIGH, 8'h3c);
        wr(ADDR_TIMER8_CTL, 8'h1e);
        @(posedge clk) stop_q <= 1'b1;
        @(posedge clk) stop_q <= 1'b0;
        rd(ADDR_T16_LOW, d); `CHK("hold kept", 8'h5a, d)
        rd(ADDR_T8_HIGH, d); `CHK("t8 kept", 8'h3c, d)
        rd(ADDR_TIMER8_CTL, d); `CHK("ctl kept", 8'h1e, d)
        wr(ADDR_TIMER8_CTL, 8'h20);
        // Waveform widths for every prescale code, high 3 and low 2
        wr(ADDR_T8_LOW, 8'h02);
        wr(ADDR_T8_HIGH, 8'h03);
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_TIMER8_CTL, 8'(8'h81 | (c << 3)));
            repeat (15 * (1 << c) + 6) @(posedge clk);
            `CHK("high width", 3 * (1 << c), hi_w)
            `CHK("low width", 2 * (1 << c), lo_w)
            wr(ADDR_TIMER8_CTL, 8'h20);
        end
        // Single pass: one terminal count, flag and one interrupt;
        // toggles counted once the stale output level has passed
        i0 = irq_cnt;
        wr(ADDR_TIMER8_CTL, 8'hc3);
        repeat (4) @(posedge clk);
        t0 = tgl;
        repeat (36) @(posedge clk);
        `CHK("single toggles", 1, tgl - t0)
        `CHK("to irq on", 1, irq_cnt - i0)
        rd(ADDR_TIMER8_CTL, d); `CHK("flag set", 1'b1, d[5])
        wr(ADDR_TIMER8_CTL, 8'h43); rd(ADDR_TIMER8_CTL, d);
        `CHK("write 0 keeps", 1'b1, d[5])
        wr(ADDR_TIMER8_CTL, 8'h63); rd(ADDR_TIMER8_CTL, d);
        `CHK("write 1 clears", 1'b0, d[5])
        // Repeat mode with the time-out interrupt masked
        t0 = tgl;
        i0 = irq_cnt;
        wr(ADDR_TIMER8_CTL, 8'h81);
        repeat (40) @(posedge clk);
        `CHK("to irq masked", 0, irq_cnt - i0)
        `CHK("reloads", 1'b1, (tgl - t0) > 4)
        // Duplicate enable alone runs the timer again
        wr(ADDR_TIMER8_CTL, 8'h01);
        wr(ADDR_THIRD_CTL, 8'h40);
        t0 = tgl;
        repeat (30) @(posedge clk);
        `CHK("dup enable", 1'b1, (tgl - t0) > 4)
        wr(ADDR_THIRD_CTL, 8'h00);
        repeat (6) @(posedge clk);
        t0 = tgl;
        repeat (30) @(posedge clk);
        `CHK("both off", 0, tgl - t0)
        // Pin 4 back to the port value
        wr(ADDR_TIMER8_CTL, 8'h00);
        @(posedge clk) p4_q <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("pin4 port 1", 1'b1, pin4)
        p4_q <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("pin4 port 0", 1'b0, pin4)
        // Pin 6 carries the OR of both outputs; 16-bit stays low
        wr(ADDR_TIMER8_CTL, 8'h81);
        wr(ADDR_SHARED_CTL, 8'h50);
        // Pin 6 lags the mode write by one cycle
        @(posedge clk);
        repeat (10) @(posedge clk) `CHK("pin6 comb", pin4, pin6)
        wr(ADDR_SHARED_CTL, 8'h00);
        @(posedge clk) p6_q <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("pin6 port", 1'b1, pin6)
        // 16-bit start value zero wraps to FFFFh without a time-out
        wr(ADDR_T16_LOW, 8'h00);
        wr(ADDR_SECOND_CTL, 8'h80);
        repeat (20) @(posedge clk);
        rd(ADDR_SECOND_CTL, d); `CHK("t16 no timeout", 8'h80, d)
        wr(ADDR_SECOND_CTL, 8'h00);
        // Demodulation: timers off before the mode change
        wr(ADDR_TIMER8_CTL, 8'h00);
        wr(ADDR_SHARED_CTL, 8'hc2);
        rd(ADDR_SHARED_CTL, d); `CHK("demod mode", 8'hc2, d)
        `CHK("pin6 in demod", 1'b1, pin6)
        wr(ADDR_TIMER8_CTL, 8'h84);
        @(posedge clk) imr_q <= 1'b1;
        c0 = cap_cnt;
        pm_u.pulse(1'b0);
        `CHK("pin1 ignored", 0, cap_cnt - c0)
        pm_u.pulse(1'b1);
        `CHK("pin0 capture", 1, cap_cnt - c0)
        wr(ADDR_SHARED_CTL, 8'h82);
        c0 = cap_cnt;
        e0 = ext_cnt;
        pm_u.pulse(1'b0);
        `CHK("pin1 capture", 1, cap_cnt - c0)
        `CHK("pin1 ext irq", 1'b1, (ext_cnt - e0) > 0)
        wr(ADDR_TIMER8_CTL, 8'h80);
        c0 = cap_cnt;
        pm_u.pulse(1'b0);
        `CHK("cap masked", 0, cap_cnt - c0)
        // 16-bit demod on falling edges: first edge captures FFFFh and
        // reloads, the next one sees eight ticks counted off
        wr(ADDR_T16_LOW, 8'hff);
        wr(ADDR_T16_HIGH, 8'hff);
        wr(ADDR_SECOND_CTL, 8'h80);
        pm_u.pulse(1'b0);
        pm_u.pulse(1'b0);
        rd(ADDR_CAP16_LOW, d); `CHK("cap16 low", 8'hf7, d)
        rd(ADDR_CAP16_HIGH, d); `CHK("cap16 high", 8'hff, d)
        give_verdict();
    end
endmodule // dttd_top_tb
